// File: shared/bil_pkg.sv
// Constants, types and timing for the boot image loader host controller.
// Assumes a single 250 MHz core clock.
package bil_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_PS   = 4000;
	localparam int unsigned BOOT_MAX_US     = 150;
	localparam int unsigned BOOT_MAX_CYC    = (BOOT_MAX_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned RST_HOLD_US     = 1;
	localparam int unsigned RST_HOLD_CYC    = (RST_HOLD_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned SCLK_HALF_CYC   = 16;
	localparam int unsigned CNT_W           = 24;

	// ----------------------------------------------------------------
	// Boot image format
	// ----------------------------------------------------------------
	localparam int unsigned  WORD_W         = 32;
	localparam int unsigned  BIT_CNT_W      = 5;
	localparam logic [4:0]   BIT_LAST       = 5'h1F;
	localparam logic [31:0]  CRC_POLY       = 32'hEDB88320;
	localparam logic [31:0]  CRC_PRESET     = 32'hFFFFFFFF;
	localparam logic [31:0]  CRC_SKIP_WORD  = 32'h0D15AB1E;
	localparam logic [31:0]  ACK_NONE_WORD  = 32'h0000FF02;

	// ----------------------------------------------------------------
	// Strap codes
	// ----------------------------------------------------------------
	localparam logic [2:0] STRAP_QSPI_MASTER = 3'h0;
	localparam logic [2:0] STRAP_SPI_MASTER  = 3'h1;
	localparam logic [2:0] STRAP_SPI_SLAVE   = 3'h2;
	localparam logic [2:0] STRAP_SPI_SLAVE2  = 3'h3;
	localparam int unsigned STRAP_LINK_BIT   = 2;
	localparam int unsigned LINK_WIRES       = 5;

	typedef struct packed {
		logic [2:0]  strap;
		logic        skip_crc;
		logic [31:0] length;
	} bil_cmd_t;

	typedef struct packed {
		logic ss_n;
		logic sclk;
		logic mosi;
	} bil_spi_t;

	typedef enum logic [5:0] {
		ST_IDLE  = 6'b000001,
		ST_RESET = 6'b000010,
		ST_WAIT  = 6'b000100,
		ST_FETCH = 6'b001000,
		ST_SHIFT = 6'b010000,
		ST_HOLD  = 6'b100000
	} bil_state_t;

endpackage : bil_pkg

// File: rtl/bil_crc32.sv
// Combinational reflected CRC-32 update over one 32-bit word, low byte first.
// Assumes the caller registers the running value.
`timescale 1ns/10ps
`default_nettype none
module bil_crc32
	import bil_pkg::*;
(
	input  wire logic [31:0] crc_i,   // Running CRC value
	input  wire logic [31:0] data_i,  // Word, bit 0 enters first
	output logic      [31:0] crc_o    // Updated CRC value
);
	logic [31:0] stage [0:WORD_W];

	assign stage[0] = crc_i;

	// ----------------------------------------------------------------
	// One shift per data bit, LSB first
	// ----------------------------------------------------------------
	genvar k;
	generate
		for (k = 0; k < WORD_W; k++) begin : g_bit
			wire fb = stage[k][0] ^ data_i[k];
			assign stage[k+1] = {1'b0, stage[k][31:1]} ^ (fb ? CRC_POLY : 32'h00000000);
		end
	endgenerate

	assign crc_o = stage[WORD_W];
endmodule : bil_crc32
`default_nettype wire

// File: rtl/bil_host.sv
// Host controller that resets a tile, straps its boot source and, in SPI slave
// boot, clocks the boot image into it as SPI master.
// Assumes the image words arrive on a valid/ready stream in the core clock domain.
`timescale 1ns/10ps
`default_nettype none
module bil_host
	import bil_pkg::*;
#(
	parameter int unsigned BOOT_WAIT_CYC = BOOT_MAX_CYC  // Shortenable for simulation
)
(
	input  wire logic                  core_clk_i,    // Core clock, 250 MHz
	input  wire logic                  arst_n_i,      // Asynchronous reset, active low
	input  wire bil_pkg::bil_cmd_t     cmd_i,         // Boot command parameters
	input  wire logic                  start_i,       // Start pulse, taken in idle or hold
	input  wire logic [31:0]           word_i,        // Program word
	input  wire logic                  word_valid_i,  // Program word valid
	output logic                       word_ready_o,  // Program word taken
	output logic                       busy_o,        // Sequence running
	output logic                       done_o,        // Sequence finished pulse
	output logic                       dev_rst_n_o,   // Device reset, active low
	output logic [2:0]                 strap_o,       // Strap pin levels
	output logic                       strap_oe_o,    // Strap pins driven
	output bil_pkg::bil_spi_t          spi_o,         // SPI select, clock, data
	output logic                       spi_oe_o,      // SPI pins driven
	output logic [LINK_WIRES-1:0]      link_o,        // Device receive wires
	output logic                       link_oe_o      // Link wires driven
);
	import bil_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	bil_state_t          state;
	bil_state_t          next_state;
	bil_cmd_t            cmd;
	logic [CNT_W-1:0]    wait_cnt;
	logic [CNT_W-1:0]    next_wait_cnt;
	logic [31:0]         words_left;
	logic [1:0]          phase;          // 0 length, 1 program, 2 check
	logic [1:0]          next_phase;
	logic [31:0]         shreg;
	logic [BIT_CNT_W-1:0] bit_cnt;
	logic [31:0]         crc;
	logic [31:0]         crc_upd;
	logic [CNT_W-1:0]    div_cnt;
	logic                sclk;
	logic                done;

	localparam logic [1:0] PH_LEN  = 2'h0;
	localparam logic [1:0] PH_PROG = 2'h1;
	localparam logic [1:0] PH_CHK  = 2'h2;

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	wire is_link   = cmd.strap[STRAP_LINK_BIT];
	wire is_slave  = (cmd.strap == STRAP_SPI_SLAVE) || (cmd.strap == STRAP_SPI_SLAVE2);
	wire in_idle   = (state == ST_IDLE);
	wire in_fetch  = (state == ST_FETCH);
	wire in_shift  = (state == ST_SHIFT);
	wire wait_over = (wait_cnt == '0);
	wire tick      = (div_cnt == '0);
	wire fall      = in_shift && tick && sclk;
	wire last_bit  = (bit_cnt == BIT_LAST);
	wire word_end  = fall && last_bit;
	wire prog_empty = (words_left == 32'h00000000);

	// Check word: skip value or inverted residue
	wire [31:0] check_word = cmd.skip_crc ? CRC_SKIP_WORD : ~crc;

	// Word selection for the next transmission
	wire        take_prog  = in_fetch && (phase == PH_PROG) && !prog_empty;
	wire        fetch_go   = in_fetch && ((phase != PH_PROG) || prog_empty || word_valid_i);
	wire [31:0] fetch_word = (phase == PH_LEN)              ? cmd.length :
	                         ((phase == PH_PROG) && !prog_empty) ? word_i :
	                         check_word;
	wire        crc_en     = fetch_go && ((phase == PH_LEN) || take_prog);

	assign word_ready_o = take_prog;

	bil_crc32 u_crc (
		.crc_i  (crc),
		.data_i (fetch_word),
		.crc_o  (crc_upd)
	);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_state    = state;
		next_wait_cnt = wait_cnt;
		next_phase    = phase;
		case (state)
			ST_IDLE: begin
				if (start_i) begin
					next_state    = ST_RESET;
					next_wait_cnt = CNT_W'(RST_HOLD_CYC);
				end
			end
			ST_RESET: begin
				if (wait_over) begin
					next_state    = ST_WAIT;
					next_wait_cnt = CNT_W'(BOOT_WAIT_CYC);
				end else begin
					next_wait_cnt = wait_cnt - 1'b1;
				end
			end
			ST_WAIT: begin
				if (!wait_over) begin
					next_wait_cnt = wait_cnt - 1'b1;
				end else if (is_slave) begin
					next_state = ST_FETCH;
					next_phase = PH_LEN;
				end else begin
					next_state = ST_HOLD;
				end
			end
			ST_FETCH: begin
				if (fetch_go) begin
					next_state = ST_SHIFT;
				end
			end
			ST_SHIFT: begin
				if (word_end) begin
					if (phase == PH_CHK) begin
						next_state = ST_HOLD;
					end else begin
						next_state = ST_FETCH;
						// Length zero goes straight to the check word
						if (prog_empty) begin
							next_phase = PH_CHK;
						end else if (phase == PH_LEN) begin
							next_phase = PH_PROG;
						end
					end
				end
			end
			ST_HOLD: begin
				if (start_i) begin
					next_state    = ST_RESET;
					next_wait_cnt = CNT_W'(RST_HOLD_CYC);
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state    <= ST_IDLE;
			wait_cnt <= '0;
			phase    <= PH_LEN;
		end else begin
			state    <= next_state;
			wait_cnt <= next_wait_cnt;
			phase    <= next_phase;
		end
	end

	// ----------------------------------------------------------------
	// Command capture and image bookkeeping
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cmd <= '0;
		end else if ((in_idle || state == ST_HOLD) && start_i) begin
			cmd <= cmd_i;
		end
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			words_left <= '0;
		end else if (in_fetch && fetch_go && phase == PH_LEN) begin
			words_left <= cmd.length;
		end else if (take_prog && word_valid_i) begin
			words_left <= words_left - 32'h00000001;
		end
	end

	// CRC runs over length word and program, never over the check word
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			crc <= CRC_PRESET;
		end else if (state == ST_WAIT) begin
			crc <= CRC_PRESET;
		end else if (crc_en) begin
			crc <= crc_upd;
		end
	end

	// ----------------------------------------------------------------
	// Serial clock divider and shifter
	// ----------------------------------------------------------------
	// Mode 0/0: data changes while the clock is low, device samples rising edge
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			div_cnt <= '0;
		end else if (!in_shift || tick) begin
			div_cnt <= CNT_W'(SCLK_HALF_CYC - 1);
		end else begin
			div_cnt <= div_cnt - 1'b1;
		end
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sclk <= 1'b0;
		end else if (!in_shift) begin
			sclk <= 1'b0;
		end else if (tick) begin
			sclk <= ~sclk;
		end
	end

	// Whole word leaves LSB first, giving low byte first and low bit first
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			shreg   <= '0;
			bit_cnt <= '0;
		end else if (in_fetch && fetch_go) begin
			shreg   <= fetch_word;
			bit_cnt <= '0;
		end else if (fall) begin
			shreg   <= {1'b0, shreg[31:1]};
			bit_cnt <= bit_cnt + 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Pins
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			dev_rst_n_o <= 1'b0;
			strap_o     <= '0;
			strap_oe_o  <= 1'b0;
			spi_o       <= '{ss_n: 1'b1, sclk: 1'b0, mosi: 1'b0};
			spi_oe_o    <= 1'b0;
			link_o      <= '0;
			link_oe_o   <= 1'b0;
		end else begin
			dev_rst_n_o <= !(next_state == ST_RESET);
			// Straps stand from reset until boot starts; slave mode shares a strap pin with data
			strap_o     <= cmd.strap;
			strap_oe_o  <= (next_state == ST_RESET) || (next_state == ST_WAIT);
			// Select follows the state one cycle late, in step with the registered clock
			spi_o.ss_n  <= !(in_fetch || in_shift);
			spi_o.sclk  <= sclk;
			spi_o.mosi  <= shreg[0];
			spi_oe_o    <= is_slave && !in_idle && (next_state != ST_RESET);
			// Hold the device's receive wires low; link traffic belongs to the user
			link_o      <= '0;
			link_oe_o   <= is_link && !in_idle;
		end
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			done <= 1'b0;
		end else begin
			done <= (state != ST_HOLD) && (next_state == ST_HOLD);
		end
	end

	assign done_o = done;
	assign busy_o = !in_idle && (state != ST_HOLD);
endmodule : bil_host
`default_nettype wire

// File: tb/bil_host_monitor.sv
// Port checker for the boot host controller.
// Assumes it is bound onto every bil_host.
`timescale 1ns/10ps
`default_nettype none
module bil_host_monitor
	import bil_pkg::*;
(
	input wire logic              core_clk_i,  // Clock
	input wire logic              arst_n_i,    // Reset, active low
	input wire bil_pkg::bil_spi_t spi_o,       // SPI pins
	input wire logic              spi_oe_o,    // SPI enable
	input wire logic [4:0]        link_o,      // Link wires
	input wire logic              link_oe_o,   // Link enable
	input wire logic              dev_rst_n_o, // Device reset
	input wire logic              strap_oe_o,  // Strap enable
	input wire logic              done_o,      // Done pulse
	input wire logic              busy_o       // Busy
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!arst_n_i);
	sequence s_hi8; spi_o.sclk [*8]; endsequence
	sequence s_lo8; !spi_o.sclk [*8]; endsequence
	property p_sclk_idle; spi_o.ss_n |-> !spi_o.sclk; endproperty
	a_sclk_idle: assert property (p_sclk_idle) else $error("sclk not idle low");
	property p_mosi_hold; spi_o.sclk |-> $stable(spi_o.mosi); endproperty
	a_mosi_hold: assert property (p_mosi_hold) else $error("mosi moved");
	property p_sclk_hi; $rose(spi_o.sclk) |-> s_hi8; endproperty
	a_sclk_hi: assert property (p_sclk_hi) else $error("sclk high short");
	property p_sclk_lo; $fell(spi_o.sclk) |-> s_lo8; endproperty
	a_sclk_lo: assert property (p_sclk_lo) else $error("sclk low short");
	property p_link_low; link_oe_o |-> link_o == 5'h00; endproperty
	a_link_low: assert property (p_link_low) else $error("link wire high");
	property p_link_excl; link_oe_o |-> !spi_oe_o; endproperty
	a_link_excl: assert property (p_link_excl) else $error("link and spi both");
	property p_strap_rst; $fell(dev_rst_n_o) |-> strap_oe_o; endproperty
	a_strap_rst: assert property (p_strap_rst) else $error("strap not driven");
	property p_rst_hold; $fell(dev_rst_n_o) |-> !dev_rst_n_o [*8]; endproperty
	a_rst_hold: assert property (p_rst_hold) else $error("reset too short");
	property p_spi_run; !spi_o.ss_n |-> dev_rst_n_o; endproperty
	a_spi_run: assert property (p_spi_run) else $error("spi in reset");
	property p_done; done_o |-> !busy_o ##1 !done_o; endproperty
	a_done: assert property (p_done) else $error("done not a pulse");
endmodule : bil_host_monitor
bind bil_host bil_host_monitor u_bil_host_monitor (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
	.spi_o(spi_o), .spi_oe_o(spi_oe_o), .link_o(link_o), .link_oe_o(link_oe_o),
	.dev_rst_n_o(dev_rst_n_o), .strap_oe_o(strap_oe_o), .done_o(done_o), .busy_o(busy_o));
`default_nettype wire

// File: tb/bil_dev_model.sv
// Device model in SPI slave boot: takes the image mode 0/0, LSB first.
// Assumes the host drives the SPI pins; counters clear in device reset.
`timescale 1ns/10ps
`default_nettype none
module bil_dev_model
	import bil_pkg::*;
(
	input  wire bil_pkg::bil_spi_t spi_i,     // Pins from host
	input  wire logic              spi_oe_i,  // Host drives SPI
	input  wire logic              rst_n_i,   // Device reset
	output logic [31:0]            n_words_o, // Words taken
	output logic [31:0]            len_o,     // Length word
	output logic [31:0]            chk_o,     // Check word
	output logic                   ok_o       // Image accepted
);
	logic [31:0] sh;
	logic [31:0] crc;
	logic [4:0]  nb;
	always @(posedge spi_i.sclk or negedge rst_n_i) begin
		if (!rst_n_i) begin
			n_words_o = 32'h0;
			len_o = 32'h0;
			chk_o = 32'h0;
			ok_o = 1'b0;
			crc = CRC_PRESET;
			nb = 5'h00;
		end else if (spi_oe_i && !spi_i.ss_n) begin
			sh = {spi_i.mosi, sh[31:1]};
			if (n_words_o == 32'h0 || n_words_o <= len_o)
				crc = (crc >> 1) ^ ((crc[0] ^ spi_i.mosi) ? CRC_POLY : 32'h0);
			nb = nb + 5'h01;
			if (nb == 5'h00) begin
				if (n_words_o == 32'h0)
					len_o = sh;
				else if (n_words_o == len_o + 32'h1) begin
					chk_o = sh;
					ok_o = (sh == CRC_SKIP_WORD) || (sh == ~crc);
				end
				n_words_o = n_words_o + 32'h1;
			end
		end
	end
endmodule : bil_dev_model
`default_nettype wire

// File: tb/bil_host_bench.sv
// Bench for the boot host controller with a device model.
// Assumes bil_host_monitor is bound separately.
`timescale 1ns/10ps
`default_nettype none
module bil_host_bench;
	import bil_pkg::*;
	logic        core_clk_i = 1'b0;
	logic        arst_n_i = 1'b0;
	bil_cmd_t    cmd_i = '0;
	logic        start_i = 1'b0;
	logic [31:0] word_i = 32'h0;
	logic        word_valid_i = 1'b0;
	logic        word_ready_o, busy_o, done_o, dev_rst_n_o, strap_oe_o, spi_oe_o, link_oe_o, rx_ok;
	logic [2:0]  strap_o;
	logic [4:0]  link_o;
	bil_spi_t    spi_o;
	logic [31:0] n_words, rx_len, rx_chk;
	int          miscompares = 0;
	int          n_compared = 0;
	int          cyc = 0;
	logic [31:0] img [3] = '{32'h12345678, 32'hA5A50F0F, 32'h00000001};
	logic [2:0]  others [6] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h6, 3'h7};
	bil_host #(.BOOT_WAIT_CYC(200)) u_bil_host (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
		.cmd_i(cmd_i), .start_i(start_i), .word_i(word_i), .word_valid_i(word_valid_i),
		.word_ready_o(word_ready_o), .busy_o(busy_o), .done_o(done_o), .dev_rst_n_o(dev_rst_n_o),
		.strap_o(strap_o), .strap_oe_o(strap_oe_o), .spi_o(spi_o), .spi_oe_o(spi_oe_o),
		.link_o(link_o), .link_oe_o(link_oe_o));
	bil_dev_model u_bil_dev_model (.spi_i(spi_o), .spi_oe_i(spi_oe_o), .rst_n_i(dev_rst_n_o),
		.n_words_o(n_words), .len_o(rx_len), .chk_o(rx_chk), .ok_o(rx_ok));
	always #2 core_clk_i = ~core_clk_i;
	task automatic tally_and_finish();
		if (miscompares == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : tally_and_finish
	// Hang guard, well above the roughly 11000 cycles the run needs
	always @(posedge core_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			miscompares++;
			tally_and_finish();
		end
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	function automatic logic [31:0] crc_of(input logic [31:0] n);
		logic [31:0] c;
		logic [31:0] w;
		c = CRC_PRESET;
		for (int i = 0; i <= n; i++) begin
			w = (i == 0) ? n : img[i-1];
			for (int b = 0; b < 32; b++)
				c = (c >> 1) ^ ((c[0] ^ w[b]) ? CRC_POLY : 32'h0);
		end
		return ~c;
	endfunction : crc_of
	task automatic kick(input logic [2:0] code, input logic skip, input logic [31:0] n);
		cmd_i = '{strap: code, skip_crc: skip, length: n};
		start_i = 1'b1;
		@(negedge core_clk_i);
		start_i = 1'b0;
		repeat (2) @(negedge core_clk_i);
		chk("dev_rst_n", 32'h0, {31'h0, dev_rst_n_o});
		chk("strap", {29'h0, code}, {29'h0, strap_o});
		chk("strap_oe", 32'h1, {31'h0, strap_oe_o});
		chk("link_oe", {31'h0, code[2]}, {31'h0, link_oe_o});
		chk("link", 32'h0, {27'h0, link_o});
		chk("busy", 32'h1, {31'h0, busy_o});
	endtask : kick
	task automatic wait_done();
		for (int k = 0; k < 20000 && done_o !== 1'b1; k++)
			@(negedge core_clk_i);
		chk("done", 32'h1, {31'h0, done_o});
		chk("busy", 32'h0, {31'h0, busy_o});
	endtask : wait_done
	task automatic t_slave(input logic [2:0] code, input logic skip, input logic [31:0] n);
		kick(code, skip, n);
		for (int i = 0; i < n; i++) begin
			word_i = img[i];
			word_valid_i = 1'b1;
			for (int k = 0; k < 5000 && word_ready_o !== 1'b1; k++)
				@(negedge core_clk_i);
			chk("word_ready", 32'h1, {31'h0, word_ready_o});
			@(negedge core_clk_i);
		end
		word_valid_i = 1'b0;
		wait_done();
		chk("words", n + 32'h2, n_words);
		chk("length", n, rx_len);
		chk("check", skip ? CRC_SKIP_WORD : crc_of(n), rx_chk);
		chk("accepted", 32'h1, {31'h0, rx_ok});
	endtask : t_slave
	task automatic t_strap(input logic [2:0] code);
		kick(code, 1'b0, 32'h0);
		wait_done();
		chk("words", 32'h0, n_words);
		chk("spi_oe", 32'h0, {31'h0, spi_oe_o});
	endtask : t_strap
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (3) @(negedge core_clk_i);
		chk("dev_rst_n", 32'h0, {31'h0, dev_rst_n_o});
		chk("spi_oe", 32'h0, {31'h0, spi_oe_o});
		chk("strap_oe", 32'h0, {31'h0, strap_oe_o});
		arst_n_i = 1'b1;
		@(negedge core_clk_i);
		t_slave(STRAP_SPI_SLAVE, 1'b0, 32'h3);
		t_slave(STRAP_SPI_SLAVE2, 1'b1, 32'h0);
		foreach (others[i])
			t_strap(others[i]);
		tally_and_finish();
	end
endmodule : bil_host_bench
`default_nettype wire
